// ### logic/port_b_pkg.sv
// constants shared by the upper port pin multiplexer
package port_b_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NUM_PINS = 4;
  localparam int FIRST_PIN = 4;
  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVELS = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_LATCH = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MAIN = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EDGES = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EXT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 6'h24;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_LATCH = 8'h00;
  localparam logic [REG_W-1:0] RST_DIR = 8'hFF;
  localparam logic [REG_W-1:0] RST_IRQ_MAIN = 8'h00;
  localparam logic [REG_W-1:0] RST_IRQ_EDGES = 8'hFF;
  localparam logic [REG_W-1:0] RST_IRQ_EXT = 8'h00;
  localparam logic [REG_W-1:0] RST_ANALOG = 8'h00;
  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int MAIN_FLAG_BIT = 0;
  localparam int MAIN_ENABLE_BIT = 3;
  localparam int EDGES_PRIO_BIT = 0;
  localparam int EDGES_PULLUP_N_BIT = 7;
  localparam int ANALOG_PIN4_BIT = 0;
  localparam int EVT_W = 2;
  localparam int EVT_CHANGE_BIT = 0;
  localparam int EVT_PROG_BIT = 1;
  localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
  // local pin index inside the upper nibble
  localparam int PIN_ADDR1 = 0;
  localparam int PIN_ADDR0 = 1;
  localparam int PIN_PCLK = 2;
  localparam int PIN_PDAT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/port_b_upper_pin_mux.sv
// upper nibble of a bidirectional port with peripheral muxing and AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module port_b_upper_pin_mux #(
  parameter logic PAR_MASTER_PRESENT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [port_b_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [port_b_pkg::DATA_W-1:0] wdata,
  input wire logic [port_b_pkg::DATA_W/8-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [port_b_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [port_b_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_in,
  output logic [port_b_pkg::NUM_PINS-1:0] pin_out,
  output logic [port_b_pkg::NUM_PINS-1:0] pin_oe,
  output logic [port_b_pkg::NUM_PINS-1:0] pullup_en,
  input wire logic prog_enable,
  output logic prog_clock_in,
  input wire logic prog_data_drive,
  input wire logic prog_data_oe_req,
  output logic prog_data_in,
  input wire logic par_port_enable,
  input wire logic [1:0] par_addr_out,
  output logic [1:0] par_addr_in,
  input wire logic serial_clk_a_enable,
  input wire logic serial_clk_a_drive,
  output logic serial_clk_a_in,
  input wire logic [port_b_pkg::NUM_PINS-1:0] remap_out_enable,
  input wire logic [port_b_pkg::NUM_PINS-1:0] remap_out_value,
  output logic [port_b_pkg::NUM_PINS-1:0] remap_in,
  output logic port_change_irq_priority,
  output logic irq
);
  import port_b_pkg::*;
  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [REG_W-1:0] output_latch_ff, direction_ff, irq_main_ff, irq_edges_ff, irq_ext_ff, analog_cfg_ff;
  logic [EVT_W-1:0] evt_status_ff, evt_enable_ff;
  // --------------------------------------------------------------
  // pin synchronisers and input conditioning
  // --------------------------------------------------------------
  logic [NUM_PINS-1:0] sync1_ff, sync2_ff, last_ff, analog_mask, prog_mask, pin_dir, pin_levels, change_vec;
  logic change_evt, prog_q_ff, prog_evt, pullup_disable_n;
  // no reset: pins keep sampling through reset, so no false change follows it
  always_ff @(posedge aclk) begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
  end
  assign pin_dir = direction_ff[FIRST_PIN +: NUM_PINS];
  assign pullup_disable_n = irq_edges_ff[EDGES_PULLUP_N_BIT];
  always_comb begin
    analog_mask = '0;
    analog_mask[PIN_ADDR1] = ~analog_cfg_ff[ANALOG_PIN4_BIT];
    prog_mask = '0;
    prog_mask[PIN_PCLK] = prog_enable;
    prog_mask[PIN_PDAT] = prog_enable;
  end
  assign pin_levels = sync2_ff & ~analog_mask;
  assign par_addr_in = {pin_levels[PIN_ADDR1] & pin_dir[PIN_ADDR1], pin_levels[PIN_ADDR0] & pin_dir[PIN_ADDR0]};
  assign serial_clk_a_in = pin_levels[PIN_ADDR1] & pin_dir[PIN_ADDR1];
  assign remap_in = pin_levels & pin_dir & ~prog_mask;
  // programming clock sampled regardless of direction
  assign prog_clock_in = sync2_ff[PIN_PCLK] & prog_enable;
  // programming data sampled while debug owns it
  assign prog_data_in = sync2_ff[PIN_PDAT] & prog_enable;
  // --------------------------------------------------------------
  // change detection
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    // tracks levels through reset too, so release sees no edge
    last_ff <= pin_levels;
    if (!aresetn) begin
      prog_q_ff <= 1'b0;
    end else begin
      prog_q_ff <= prog_enable;
    end
  end
  assign change_vec = pin_dir & ~prog_mask & (pin_levels ^ last_ff);
  assign change_evt = |change_vec;
  assign prog_evt = prog_enable & ~prog_q_ff;

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  logic [NUM_PINS-1:0] nxt_pin_out, nxt_pin_oe, nxt_pullup_en, pin_out_ff, pin_oe_ff, pullup_en_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_comb begin
        nxt_pin_oe[gi] = ~pin_dir[gi];
        nxt_pin_out[gi] = output_latch_ff[FIRST_PIN + gi];
        if (!pin_dir[gi] && remap_out_enable[gi]) begin
          nxt_pin_out[gi] = remap_out_value[gi];
        end
        // serial clock output on pin 4
        if (gi == PIN_ADDR1 && !pin_dir[gi] && serial_clk_a_enable) begin
          nxt_pin_out[gi] = serial_clk_a_drive;
        end
        // master address only on the larger package
        if ((gi == PIN_ADDR1 || gi == PIN_ADDR0) && !pin_dir[gi] && par_port_enable && PAR_MASTER_PRESENT) begin
          nxt_pin_out[gi] = (gi == PIN_ADDR1) ? par_addr_out[1] : par_addr_out[0];
        end
        nxt_pullup_en[gi] = pin_dir[gi] & ~pullup_disable_n & ~analog_mask[gi];
        if (gi == PIN_PCLK && prog_enable) begin
          nxt_pin_oe[gi] = 1'b0;
          nxt_pullup_en[gi] = 1'b0;
        end
        // debug unit owns the data pin
        if (gi == PIN_PDAT && prog_enable) begin
          nxt_pin_oe[gi] = prog_data_oe_req;
          nxt_pin_out[gi] = prog_data_drive;
          nxt_pullup_en[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
      pullup_en_ff <= '0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pullup_en_ff <= nxt_pullup_en;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign pullup_en = pullup_en_ff;

  // --------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [REG_W-1:0] wbyte_ff;
  logic wlane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic wr_hit;
  logic wr_ok;

  assign awready = ~aw_held_ff & ~bvalid_ff;
  assign wready = ~w_held_ff & ~bvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  always_comb begin
    case (awaddr_ff)
      OFS_PIN_LEVELS, OFS_OUT_LATCH, OFS_DIRECTION, OFS_IRQ_MAIN, OFS_IRQ_EDGES,
      OFS_IRQ_EXT, OFS_ANALOG_CFG, OFS_EVT_CLEAR, OFS_EVT_ENABLE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // only byte lane 0 carries register bits
  assign wr_ok = do_write & wr_hit & wlane_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= '0;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wbyte_ff <= wdata[REG_W-1:0];
        wlane_ff <= wstrb[0];
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // register updates
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latch_ff <= RST_LATCH;
      direction_ff <= RST_DIR;
      irq_edges_ff <= RST_IRQ_EDGES;
      irq_ext_ff <= RST_IRQ_EXT;
      analog_cfg_ff <= RST_ANALOG;
      evt_enable_ff <= RST_EVT;
    end else if (wr_ok) begin
      // writing the pin level register lands in the latch
      case (awaddr_ff)
        OFS_PIN_LEVELS, OFS_OUT_LATCH: output_latch_ff <= wbyte_ff;
        OFS_DIRECTION: direction_ff <= wbyte_ff;
        OFS_IRQ_EDGES: irq_edges_ff <= wbyte_ff;
        OFS_IRQ_EXT: irq_ext_ff <= wbyte_ff;
        OFS_ANALOG_CFG: analog_cfg_ff <= wbyte_ff;
        OFS_EVT_ENABLE: evt_enable_ff <= wbyte_ff[EVT_W-1:0];
        default: begin end
      endcase
    end
  end

  logic [REG_W-1:0] nxt_irq_main;
  logic [EVT_W-1:0] nxt_evt_status;

  always_comb begin
    nxt_irq_main = irq_main_ff;
    if (wr_ok && awaddr_ff == OFS_IRQ_MAIN) begin
      nxt_irq_main = wbyte_ff;
    end
    // a fresh change beats a software clear
    if (change_evt) begin
      nxt_irq_main[MAIN_FLAG_BIT] = 1'b1;
    end
    nxt_evt_status = evt_status_ff;
    if (wr_ok && awaddr_ff == OFS_EVT_CLEAR) begin
      nxt_evt_status = evt_status_ff & ~wbyte_ff[EVT_W-1:0];
    end
    nxt_evt_status[EVT_CHANGE_BIT] = nxt_evt_status[EVT_CHANGE_BIT] | change_evt;
    nxt_evt_status[EVT_PROG_BIT] = nxt_evt_status[EVT_PROG_BIT] | prog_evt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_main_ff <= RST_IRQ_MAIN;
      evt_status_ff <= RST_EVT;
    end else begin
      irq_main_ff <= nxt_irq_main;
      evt_status_ff <= nxt_evt_status;
    end
  end

  // any enabled event flag or the enabled main change flag raises the interrupt
  assign irq = (|(evt_status_ff & evt_enable_ff)) | (irq_main_ff[MAIN_FLAG_BIT] & irq_main_ff[MAIN_ENABLE_BIT]);
  assign port_change_irq_priority = irq_edges_ff[EDGES_PRIO_BIT];

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  logic rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [REG_W-1:0] rd_byte;
  logic rd_hit;

  assign arready = ~rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    rd_byte = '0;
    rd_hit = 1'b1;
    case (araddr)
      OFS_PIN_LEVELS: rd_byte = {pin_levels, {FIRST_PIN{1'b0}}};
      OFS_OUT_LATCH: rd_byte = output_latch_ff;
      OFS_DIRECTION: rd_byte = direction_ff;
      OFS_IRQ_MAIN: rd_byte = irq_main_ff;
      OFS_IRQ_EDGES: rd_byte = irq_edges_ff;
      OFS_IRQ_EXT: rd_byte = irq_ext_ff;
      OFS_ANALOG_CFG: rd_byte = analog_cfg_ff;
      OFS_EVT_STATUS: rd_byte = {{(REG_W-EVT_W){1'b0}}, evt_status_ff};
      OFS_EVT_CLEAR: rd_byte = '0;
      OFS_EVT_ENABLE: rd_byte = {{(REG_W-EVT_W){1'b0}}, evt_enable_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// ### tb/pin_board_model.sv
// model of the circuitry wired to the upper port pins
`timescale 1ns/1ps
module pin_board_model (
  input wire logic aclk,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pullup_en,
  input wire logic [port_b_pkg::NUM_PINS-1:0] ext_val,
  input wire logic [port_b_pkg::NUM_PINS-1:0] ext_en,
  output logic [port_b_pkg::NUM_PINS-1:0] pin_in
);
  import port_b_pkg::*;
  logic [NUM_PINS-1:0] last_ff;
  // an undriven line without pull-up wanders, so a stale level never looks valid
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_ff[i];
    end
  end
  always_ff @(posedge aclk) last_ff <= pin_in;
endmodule

// ### tb/pin_mux_monitor.sv
// assertions on the pin side of the upper port multiplexer
`timescale 1ns/1ps
module pin_mux_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_in,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_out,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic [port_b_pkg::NUM_PINS-1:0] pullup_en,
  input wire logic prog_enable,
  input wire logic prog_clock_in,
  input wire logic prog_data_drive,
  input wire logic prog_data_oe_req,
  input wire logic prog_data_in,
  input wire logic par_port_enable,
  input wire logic [1:0] par_addr_out,
  input wire logic serial_clk_a_enable,
  input wire logic serial_clk_a_drive,
  input wire logic [port_b_pkg::NUM_PINS-1:0] remap_out_enable,
  input wire logic [port_b_pkg::NUM_PINS-1:0] remap_out_value,
  input wire logic irq
);
  import port_b_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------
  // pin outputs are registered: compare to inputs one edge back
  // ------------------------------------------------
  reset_quiet_a: assert property ($rose(aresetn) |-> pin_oe == 4'h0 && pullup_en == 4'h0 && !irq)
    else $error("pins active after reset");
  pclk_input_a: assert property ($past(prog_enable) |-> !pin_oe[PIN_PCLK])
    else $error("programming clock pin driven");
  pdat_drive_a: assert property (
    $past(prog_enable) && $past(prog_enable, 2) |-> pin_oe[PIN_PDAT] == $past(prog_data_oe_req)
    && (!pin_oe[PIN_PDAT] || pin_out[PIN_PDAT] == $past(prog_data_drive)))
    else $error("programming data pin not under debug control");
  pclk_follow_a: assert property (
    (prog_enable && $stable(pin_in[PIN_PCLK]))[*4] |-> prog_clock_in == pin_in[PIN_PCLK])
    else $error("programming clock not sampled");
  pdat_sample_a: assert property (
    (prog_enable && $stable(pin_in[PIN_PDAT]))[*4] |-> prog_data_in == pin_in[PIN_PDAT])
    else $error("programming data not sampled");
  par_addr_a: assert property ($past(par_port_enable) |->
    (!pin_oe[PIN_ADDR1] || pin_out[PIN_ADDR1] == $past(par_addr_out[1]))
    && (!pin_oe[PIN_ADDR0] || pin_out[PIN_ADDR0] == $past(par_addr_out[0])))
    else $error("parallel address not on pins");
  serial_clk_a: assert property (
    $past(serial_clk_a_enable) && !$past(par_port_enable) && pin_oe[PIN_ADDR1]
    |-> pin_out[PIN_ADDR1] == $past(serial_clk_a_drive))
    else $error("serial clock not on pin");
  remap_out_a: assert property (
    $past(remap_out_enable[PIN_PCLK]) && !$past(prog_enable) && pin_oe[PIN_PCLK]
    |-> pin_out[PIN_PCLK] == $past(remap_out_value[PIN_PCLK]))
    else $error("remap output not on pin");
  cover property ($rose(irq));
  cover property (prog_enable && pin_oe[PIN_PDAT]);
  cover property (par_port_enable && pin_oe[PIN_ADDR0]);
endmodule
bind port_b_upper_pin_mux pin_mux_monitor mon (.aclk, .aresetn, .pin_in, .pin_out, .pin_oe, .pullup_en,
  .prog_enable, .prog_clock_in, .prog_data_drive, .prog_data_oe_req, .prog_data_in, .par_port_enable,
  .par_addr_out, .serial_clk_a_enable, .serial_clk_a_drive, .remap_out_enable, .remap_out_value, .irq);

// ### tb/port_b_upper_pin_mux_bench.sv
// self-checking bench for the upper port pin multiplexer
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module port_b_upper_pin_mux_bench;
  import port_b_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, prog_clock_in, prog_data_in, serial_clk_a_in;
  logic port_change_irq_priority, irq;
  logic [1:0] bresp, rresp, par_addr_in, rd_resp, wr_resp;
  logic [1:0] par_addr_out = 2'h0;
  logic prog_enable = 1'b0, prog_data_drive = 1'b0, prog_data_oe_req = 1'b0, par_port_enable = 1'b0;
  logic serial_clk_a_enable = 1'b0, serial_clk_a_drive = 1'b0;
  logic [3:0] remap_out_enable = 4'h0, remap_out_value = 4'h0, ext_val = 4'h0, ext_en = 4'hF;
  logic [3:0] pin_in, pin_out, pin_oe, pullup_en, remap_in;
  int bad_count = 0;
  int total_checks = 0;
  always #12.5 aclk = ~aclk;
  port_b_upper_pin_mux uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pin_in, .pin_out,
    .pin_oe, .pullup_en, .prog_enable, .prog_clock_in, .prog_data_drive, .prog_data_oe_req, .prog_data_in,
    .par_port_enable, .par_addr_out, .par_addr_in, .serial_clk_a_enable, .serial_clk_a_drive, .serial_clk_a_in,
    .remap_out_enable, .remap_out_value, .remap_in, .port_change_irq_priority, .irq);
  pin_board_model board (.aclk, .pin_out, .pin_oe, .pullup_en, .ext_val, .ext_en, .pin_in);
  // ------------------------------------------------
  // bus and report tasks
  // ------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t bus answer missing", $time);
      final_report();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    wr_resp = bresp;
    guard(bvalid);
    // idle edge so a following call never re-drives bready in the same step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    rd_data = rdata;
    rd_resp = rresp;
    guard(rvalid);
    @(posedge aclk);
  endtask
  task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_data, {24'h0, e});
    `CHK(rd_resp, RESP_OKAY);
  endtask
  // two sync edges, flag and output register, plus margin
  task automatic settle();
    repeat (5) @(posedge aclk);
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset();
    `CHK(pin_oe, 4'h0);
    `CHK(pullup_en, 4'h0);
    chk_rd(OFS_DIRECTION, RST_DIR);
    chk_rd(OFS_IRQ_EDGES, RST_IRQ_EDGES);
    chk_rd(OFS_ANALOG_CFG, 8'h00);
    ext_val <= 4'hF;
    settle();
    chk_rd(OFS_PIN_LEVELS, 8'hE0);
    rd(6'h3C);
    `CHK(rd_resp, RESP_SLVERR);
    wr(6'h3C, 8'h55);
    `CHK(wr_resp, RESP_SLVERR);
    wr(OFS_OUT_LATCH, 8'hF0, 4'h0);
    chk_rd(OFS_OUT_LATCH, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_irq();
    wr(OFS_EVT_CLEAR, 8'h03);
    wr(OFS_IRQ_MAIN, 8'h08);
    wr(OFS_EVT_ENABLE, 8'h01);
    settle();
    `CHK(irq, 1'b0);
    ext_val <= 4'hD;
    settle();
    `CHK(irq, 1'b1);
    chk_rd(OFS_IRQ_MAIN, 8'h09);
    chk_rd(OFS_EVT_STATUS, 8'h01);
    wr(OFS_EVT_ENABLE, 8'h00);
    wr(OFS_IRQ_MAIN, 8'h01);
    settle();
    `CHK(irq, 1'b0);
    wr(OFS_EVT_CLEAR, 8'h01);
    chk_rd(OFS_EVT_STATUS, 8'h00);
    chk_rd(OFS_EVT_CLEAR, 8'h00);
    wr(OFS_IRQ_MAIN, 8'h08);
    settle();
    `CHK(irq, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic t_input();
    wr(OFS_ANALOG_CFG, 8'h01);
    wr(OFS_IRQ_EDGES, 8'h7F);
    ext_val <= 4'h6;
    settle();
    `CHK(pullup_en, 4'hF);
    `CHK(port_change_irq_priority, 1'b1);
    chk_rd(OFS_PIN_LEVELS, 8'h60);
    ext_en <= 4'h0;
    settle();
    chk_rd(OFS_PIN_LEVELS, 8'hF0);
    ext_en <= 4'hF;
    ext_val <= 4'h7;
    wr(OFS_ANALOG_CFG, 8'h00);
    settle();
    `CHK(pullup_en, 4'hE);
    chk_rd(OFS_PIN_LEVELS, 8'h60);
    $display("input test done");
  endtask
  task automatic t_output();
    ext_en <= 4'h0;
    wr(OFS_OUT_LATCH, 8'hA0);
    wr(OFS_DIRECTION, 8'h00);
    settle();
    `CHK(pin_oe, 4'hF);
    `CHK(pin_out, 4'hA);
    `CHK(pullup_en, 4'h0);
    wr(OFS_PIN_LEVELS, 8'h50);
    settle();
    `CHK(pin_out, 4'h5);
    chk_rd(OFS_OUT_LATCH, 8'h50);
    $display("output test done");
  endtask
  task automatic t_periph();
    par_port_enable <= 1'b1;
    par_addr_out <= 2'h1;
    settle();
    `CHK(pin_out, 4'h6);
    par_port_enable <= 1'b0;
    serial_clk_a_enable <= 1'b1;
    settle();
    `CHK(pin_out, 4'h4);
    serial_clk_a_enable <= 1'b0;
    remap_out_enable <= 4'hF;
    remap_out_value <= 4'hA;
    settle();
    `CHK(pin_out, 4'hA);
    remap_out_enable <= 4'h0;
    ext_en <= 4'hF;
    ext_val <= 4'h9;
    wr(OFS_ANALOG_CFG, 8'h01);
    wr(OFS_DIRECTION, 8'hFF);
    par_port_enable <= 1'b1;
    serial_clk_a_enable <= 1'b1;
    settle();
    `CHK(pin_oe, 4'h0);
    `CHK(par_addr_in, 2'h2);
    `CHK(serial_clk_a_in, 1'b1);
    `CHK(remap_in, 4'h9);
    par_port_enable <= 1'b0;
    serial_clk_a_enable <= 1'b0;
    $display("peripheral test done");
  endtask
  task automatic t_prog();
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_EVT_CLEAR, 8'h03);
    ext_en <= 4'h4;
    ext_val <= 4'h4;
    remap_out_enable <= 4'hF;
    remap_out_value <= 4'h0;
    prog_enable <= 1'b1;
    prog_data_oe_req <= 1'b1;
    prog_data_drive <= 1'b1;
    settle();
    `CHK(pin_oe, 4'hB);
    `CHK(pin_out[PIN_PDAT], 1'b1);
    `CHK(prog_clock_in, 1'b1);
    chk_rd(OFS_EVT_STATUS, 8'h02);
    ext_val <= 4'h0;
    settle();
    `CHK(prog_clock_in, 1'b0);
    prog_data_oe_req <= 1'b0;
    ext_en <= 4'hC;
    ext_val <= 4'h8;
    settle();
    `CHK(pin_oe, 4'h3);
    `CHK(prog_data_in, 1'b1);
    prog_enable <= 1'b0;
    remap_out_enable <= 4'h0;
    settle();
    `CHK(pin_oe, 4'hF);
    $display("programming test done");
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_irq();
    t_input();
    t_output();
    t_periph();
    t_prog();
    final_report();
  end
endmodule
